//--- verilog/motion_qual_pkg.sv
// Constants shared by the motion state qualifier and its settle counters.
// Assumes a 200 MHz system clock and acceleration codes at 64 counts per g.
package motion_qual_pkg;
  // Register offsets on the two-wire bus
  localparam logic [7:0] ORIENT_SETTLE_OFS = 8'h28;
  localparam logic [7:0] WAKE_SETTLE_OFS = 8'h29;
  localparam logic [7:0] SLEEP_SETTLE_OFS = 8'h2A;
  localparam logic [7:0] WAKE_LIMIT_OFS = 8'h5A;
  localparam logic [7:0] SLEEP_LIMIT_OFS = 8'h5B;
  localparam logic [7:0] FLAT_INCLINE_OFS = 8'h5C;
  localparam logic [7:0] DEADBAND_OFS = 8'h5F;
  // Values after reset
  localparam logic [7:0] ORIENT_SETTLE_RST = 8'h00;
  localparam logic [7:0] WAKE_SETTLE_RST = 8'h00;
  localparam logic [7:0] SLEEP_SETTLE_RST = 8'h00;
  localparam logic [7:0] WAKE_LIMIT_RST = 8'h20;
  localparam logic [7:0] SLEEP_LIMIT_RST = 8'h60;
  localparam logic [7:0] FLAT_INCLINE_RST = 8'h1C;
  localparam logic [1:0] FACTORY_TRIM_RST = 2'h0;
  localparam logic [3:0] DEADBAND_CODE_RST = 4'h8;
  // Deadband register field positions
  localparam int FACTORY_TRIM_LSB = 6;
  localparam int DEADBAND_CODE_LSB = 0;
  // Bus target address; value is arbitrary
  localparam logic [6:0] BUS_ADDR = 7'h0F;
  // Sample period derived from the system clock
  localparam int MCLK_HZ = 200_000_000;
  localparam int SAMPLE_RATE_HZ = 40;
  localparam int SAMPLE_CYCLES = MCLK_HZ / SAMPLE_RATE_HZ;
  // Settle count scaling as a shift: one period or sixteen periods per count
  localparam int ORIENT_SCALE_SHIFT = 0;
  localparam int WAKE_SCALE_SHIFT = 0;
  localparam int SLEEP_SCALE_SHIFT = 4;
  // Rotation enter and leave limits per deadband code, code 0 in the low byte
  localparam logic [127:0] ROT_ENTER_TABLE = {8'h3D, 8'h3D, 8'h3C, 8'h3B, 8'h3A, 8'h39,
    8'h38, 8'h37, 8'h36, 8'h35, 8'h34, 8'h33, 8'h31, 8'h30, 8'h2F, 8'h2D};
  localparam logic [127:0] ROT_LEAVE_TABLE = {8'h13, 8'h15, 8'h17, 8'h18, 8'h1A, 8'h1C,
    8'h1E, 8'h20, 8'h22, 8'h24, 8'h25, 8'h27, 8'h29, 8'h2A, 8'h2C, 8'h2D};

  typedef enum logic [2:0] {
    FACE_UP = 3'h0, ROT_0 = 3'h1, ROT_90 = 3'h3, ROT_180 = 3'h2, ROT_270 = 3'h6,
    FACE_DOWN = 3'h7
  } orient_e;

  typedef enum logic [3:0] {
    BUS_IDLE = 4'h0, BUS_ADDR_IN = 4'h1, BUS_ADDR_ACK = 4'h3, BUS_PTR_IN = 4'h2,
    BUS_PTR_ACK = 4'h6, BUS_WR_IN = 4'h7, BUS_WR_ACK = 4'h5, BUS_RD_OUT = 4'h4,
    BUS_RD_ACK = 4'hC
  } bus_state_e;
endpackage

//--- verilog/settle_if.sv
// Carrier between the qualifier top and one settle counter.
// Assumes the owner drives tick, pending and limit on the system clock.
`timescale 1ns/1ps
interface settle_if;
  logic tick;
  logic pending;
  logic [7:0] limit;
  logic accept;
  modport owner (output tick, output pending, output limit, input accept);
  modport qual (input tick, input pending, input limit, output accept);
endinterface // settle_if

//--- verilog/settle_qualifier.sv
// One settle counter: accepts a pending state after it persists long enough.
// Assumes pending is stable between sample ticks and tick is a one-cycle pulse.
`timescale 1ns/1ps
module settle_qualifier
  import motion_qual_pkg::*;
#(
  parameter int SCALE_SHIFT = 0
) (
  input wire logic mclk,
  input wire logic resetn,
  settle_if.qual s
);
  logic [11:0] count_r;
  logic accept_r;
  logic [11:0] target;

  // Limit scaled to sample periods, sixteen per count for the slow counter
  assign target = 12'(s.limit) << SCALE_SHIFT;
  assign s.accept = accept_r;

  // Count ticks while pending; a reverted candidate starts over from zero
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      count_r <= 12'h000;
      accept_r <= 1'b0;
    end else begin
      accept_r <= 1'b0;
      if (!s.pending) begin
        count_r <= 12'h000;
      end else if (s.tick) begin
        if (count_r >= target) begin
          accept_r <= 1'b1;
          count_r <= 12'h000;
        end else begin
          count_r <= count_r + 12'h001;
        end
      end
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  property p_restart;
    !s.pending |=> count_r == 12'h000;
  endproperty
  a_restart: assert property (p_restart) else $error("settle count kept after revert");

  property p_accept_cause;
    accept_r |-> $past(s.pending && s.tick && count_r >= target);
  endproperty
  a_accept_cause: assert property (p_accept_cause) else $error("accept without full count");

  property p_count_full;
    s.pending && s.tick && count_r >= target |=> accept_r;
  endproperty
  a_count_full: assert property (p_count_full) else $error("full count not accepted");
endmodule // settle_qualifier

//--- verilog/motion_state_qualifier_config.sv
// Orientation and activity qualifier with its settings registers on the two-wire bus.
// Assumes acceleration codes come from front-end logic on mclk; bus pins are asynchronous.
`timescale 1ns/1ps
module motion_state_qualifier_config
  import motion_qual_pkg::*;
#(
  parameter int SAMPLE_CYCLES_P = SAMPLE_CYCLES
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic scl,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  input wire logic signed [8:0] accelX,
  input wire logic signed [8:0] accelY,
  input wire logic signed [8:0] accelZ,
  output orient_e orientation,
  output logic orientChange,
  output logic active,
  output logic wakeEvent,
  output logic sleepEvent
);
  // Settings registers
  logic [7:0] orientSettle_r, wakeSettle_r, sleepSettle_r;
  logic [7:0] wakeLimit_r, sleepLimit_r, flatIncline_r;
  logic [1:0] factoryTrim_r;
  logic [3:0] deadbandCode_r;
  // Bus pin sampling and decoding
  logic [2:0] sclS_r, sdaS_r;
  logic sclF_r, sdaF_r, sclP_r, sdaP_r;
  logic sclRise, sclFall, startCond, stopCond;
  bus_state_e busState_r;
  logic [3:0] bitCnt_r;
  logic [7:0] shift_r, txData_r, regPtr_r;
  logic readMode_r, masterNak_r, sdaOe_r, sdaOut_r;
  logic wrEn;
  logic [7:0] rdData;
  // Sample timing and motion state
  logic [22:0] divCnt_r;
  logic tick_r;
  orient_e orient_r, candHeld_r, candPrev_r, cand;
  logic active_r, overHeld_r, underHeld_r;
  logic orientChange_r, wakeEvent_r, sleepEvent_r;
  logic signed [8:0] prevX_r, prevY_r, prevZ_r;
  logic [8:0] magX, magY;
  logic [9:0] dX, dY, dZ;
  logic [7:0] enterLim, leaveLim;
  logic flat, anyOver, allUnder;

  settle_if orientIf ();
  settle_if wakeIf ();
  settle_if sleepIf ();

  function automatic logic [8:0] mag9(input logic signed [8:0] v);
    mag9 = v[8] ? 9'(-v) : 9'(v);
  endfunction

  function automatic logic [9:0] delta10(input logic signed [8:0] a, input logic signed [8:0] b);
    logic signed [9:0] d;
    d = 10'(a) - 10'(b);
    delta10 = d[9] ? 10'(-d) : 10'(d);
  endfunction

  // Three-stage pin sampling; a level counts once stages two and three agree
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      sclS_r <= 3'h7;
      sdaS_r <= 3'h7;
      sclF_r <= 1'b1;
      sdaF_r <= 1'b1;
      sclP_r <= 1'b1;
      sdaP_r <= 1'b1;
    end else begin
      sclS_r <= {sclS_r[1:0], scl};
      sdaS_r <= {sdaS_r[1:0], sdaIn};
      if (sclS_r[1] == sclS_r[2]) sclF_r <= sclS_r[2];
      if (sdaS_r[1] == sdaS_r[2]) sdaF_r <= sdaS_r[2];
      sclP_r <= sclF_r;
      sdaP_r <= sdaF_r;
    end
  end

  assign sclRise = sclF_r & ~sclP_r;
  assign sclFall = ~sclF_r & sclP_r;
  assign startCond = sclF_r & sclP_r & sdaP_r & ~sdaF_r;
  assign stopCond = sclF_r & sclP_r & ~sdaP_r & sdaF_r;
  assign wrEn = (busState_r == BUS_WR_IN) && sclFall && (bitCnt_r == 4'h8);

  // Read mux; unmapped offsets read as zero, deadband bits 5:4 always zero
  always_comb begin
    unique case (regPtr_r)
      ORIENT_SETTLE_OFS: rdData = orientSettle_r;
      WAKE_SETTLE_OFS: rdData = wakeSettle_r;
      SLEEP_SETTLE_OFS: rdData = sleepSettle_r;
      WAKE_LIMIT_OFS: rdData = wakeLimit_r;
      SLEEP_LIMIT_OFS: rdData = sleepLimit_r;
      FLAT_INCLINE_OFS: rdData = flatIncline_r;
      DEADBAND_OFS: rdData = {factoryTrim_r, 2'b00, deadbandCode_r};
      default: rdData = 8'h00;
    endcase
  end

  // Bus target: address match, pointer, auto-incrementing data phases
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      busState_r <= BUS_IDLE;
      bitCnt_r <= 4'h0;
      shift_r <= 8'h00;
      txData_r <= 8'h00;
      regPtr_r <= 8'h00;
      readMode_r <= 1'b0;
      masterNak_r <= 1'b0;
      sdaOe_r <= 1'b0;
    end else if (startCond) begin
      busState_r <= BUS_ADDR_IN;
      bitCnt_r <= 4'h0;
      sdaOe_r <= 1'b0;
    end else if (stopCond) begin
      busState_r <= BUS_IDLE;
      sdaOe_r <= 1'b0;
    end else if (sclRise) begin
      if (busState_r == BUS_ADDR_IN || busState_r == BUS_PTR_IN || busState_r == BUS_WR_IN) begin
        shift_r <= {shift_r[6:0], sdaF_r};
        bitCnt_r <= bitCnt_r + 4'h1;
      end
      if (busState_r == BUS_RD_ACK) masterNak_r <= sdaF_r;
    end else if (sclFall) begin
      unique case (busState_r)
        BUS_IDLE: sdaOe_r <= 1'b0;
        BUS_ADDR_IN: if (bitCnt_r == 4'h8) begin
          if (shift_r[7:1] == BUS_ADDR) begin
            busState_r <= BUS_ADDR_ACK;
            readMode_r <= shift_r[0];
            sdaOe_r <= 1'b1;
          end else begin
            busState_r <= BUS_IDLE; // Another target is addressed
          end
        end
        BUS_ADDR_ACK: begin
          bitCnt_r <= 4'h0;
          if (readMode_r) begin
            busState_r <= BUS_RD_OUT;
            txData_r <= {rdData[6:0], 1'b0};
            sdaOe_r <= ~rdData[7];
            regPtr_r <= regPtr_r + 8'h01;
          end else begin
            busState_r <= BUS_PTR_IN;
            sdaOe_r <= 1'b0;
          end
        end
        BUS_PTR_IN: if (bitCnt_r == 4'h8) begin
          regPtr_r <= shift_r;
          busState_r <= BUS_PTR_ACK;
          sdaOe_r <= 1'b1;
        end
        BUS_PTR_ACK, BUS_WR_ACK: begin
          busState_r <= BUS_WR_IN;
          bitCnt_r <= 4'h0;
          sdaOe_r <= 1'b0;
        end
        BUS_WR_IN: if (bitCnt_r == 4'h8) begin
          regPtr_r <= regPtr_r + 8'h01;
          busState_r <= BUS_WR_ACK;
          sdaOe_r <= 1'b1;
        end
        BUS_RD_OUT: begin
          if (bitCnt_r == 4'h7) begin
            busState_r <= BUS_RD_ACK;
            sdaOe_r <= 1'b0; // Release so the controller can answer
          end else begin
            bitCnt_r <= bitCnt_r + 4'h1;
            sdaOe_r <= ~txData_r[7];
            txData_r <= {txData_r[6:0], 1'b0};
          end
        end
        BUS_RD_ACK: begin
          if (masterNak_r) begin
            busState_r <= BUS_IDLE;
          end else begin
            busState_r <= BUS_RD_OUT;
            bitCnt_r <= 4'h0;
            txData_r <= {rdData[6:0], 1'b0};
            sdaOe_r <= ~rdData[7];
            regPtr_r <= regPtr_r + 8'h01;
          end
        end
      endcase
    end
  end

  // Open-drain pin: the driven level is always low
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) sdaOut_r <= 1'b0;
    else sdaOut_r <= 1'b0;
  end

  // Settings registers; trim bits are stored as written, the host preserves them
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      orientSettle_r <= ORIENT_SETTLE_RST;
      wakeSettle_r <= WAKE_SETTLE_RST;
      sleepSettle_r <= SLEEP_SETTLE_RST;
      wakeLimit_r <= WAKE_LIMIT_RST;
      sleepLimit_r <= SLEEP_LIMIT_RST;
      flatIncline_r <= FLAT_INCLINE_RST;
      factoryTrim_r <= FACTORY_TRIM_RST;
      deadbandCode_r <= DEADBAND_CODE_RST;
    end else if (wrEn) begin
      unique case (regPtr_r)
        ORIENT_SETTLE_OFS: orientSettle_r <= shift_r;
        WAKE_SETTLE_OFS: wakeSettle_r <= shift_r;
        SLEEP_SETTLE_OFS: sleepSettle_r <= shift_r;
        WAKE_LIMIT_OFS: wakeLimit_r <= shift_r;
        SLEEP_LIMIT_OFS: sleepLimit_r <= shift_r;
        FLAT_INCLINE_OFS: flatIncline_r <= shift_r; // Below ten degrees is not guarded
        DEADBAND_OFS: begin
          factoryTrim_r <= shift_r[FACTORY_TRIM_LSB +: 2];
          deadbandCode_r <= shift_r[DEADBAND_CODE_LSB +: 4];
        end
        default: ;
      endcase
    end
  end

  // Sample period divider; one-cycle tick per output sample
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      divCnt_r <= 23'h000000;
      tick_r <= 1'b0;
    end else if (divCnt_r == 23'(SAMPLE_CYCLES_P - 1)) begin
      divCnt_r <= 23'h000000;
      tick_r <= 1'b1;
    end else begin
      divCnt_r <= divCnt_r + 23'h000001;
      tick_r <= 1'b0;
    end
  end

  // Orientation candidate from incline and hysteresis windows
  assign magX = mag9(accelX);
  assign magY = mag9(accelY);
  assign enterLim = ROT_ENTER_TABLE[{deadbandCode_r, 3'b000} +: 8];
  assign leaveLim = ROT_LEAVE_TABLE[{deadbandCode_r, 3'b000} +: 8];
  assign flat = (magX < {1'b0, flatIncline_r}) && (magY < {1'b0, flatIncline_r});
  always_comb begin
    cand = orient_r; // Outside every window the current screen state holds
    if (flat) begin
      cand = accelZ[8] ? FACE_DOWN : FACE_UP;
    end else if (magY > {1'b0, enterLim} && magX < {1'b0, leaveLim}) begin
      cand = accelY[8] ? ROT_180 : ROT_0;
    end else if (magX > {1'b0, enterLim} && magY < {1'b0, leaveLim}) begin
      cand = accelX[8] ? ROT_270 : ROT_90;
    end
  end

  // Per-axis change against the previous sample
  assign dX = delta10(accelX, prevX_r);
  assign dY = delta10(accelY, prevY_r);
  assign dZ = delta10(accelZ, prevZ_r);
  assign anyOver = (dX > 10'(wakeLimit_r)) || (dY > 10'(wakeLimit_r))
    || (dZ > 10'(wakeLimit_r));
  assign allUnder = (dX < 10'(sleepLimit_r)) && (dY < 10'(sleepLimit_r))
    && (dZ < 10'(sleepLimit_r));

  // Candidates are captured once per sample so the counters see stable inputs
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      candHeld_r <= FACE_UP;
      candPrev_r <= FACE_UP;
      overHeld_r <= 1'b0;
      underHeld_r <= 1'b0;
      prevX_r <= 9'h000;
      prevY_r <= 9'h000;
      prevZ_r <= 9'h000;
    end else if (tick_r) begin
      candPrev_r <= candHeld_r;
      candHeld_r <= cand;
      overHeld_r <= anyOver;
      underHeld_r <= allUnder;
      prevX_r <= accelX;
      prevY_r <= accelY;
      prevZ_r <= accelZ;
    end
  end

  // Settle counters; a changed candidate counts as a revert
  assign orientIf.tick = tick_r;
  assign orientIf.pending = (candHeld_r != orient_r) && (candHeld_r == candPrev_r);
  assign orientIf.limit = orientSettle_r;
  assign wakeIf.tick = tick_r;
  assign wakeIf.pending = !active_r && overHeld_r;
  assign wakeIf.limit = wakeSettle_r;
  assign sleepIf.tick = tick_r;
  assign sleepIf.pending = active_r && underHeld_r;
  assign sleepIf.limit = sleepSettle_r;

  settle_qualifier #(.SCALE_SHIFT(ORIENT_SCALE_SHIFT)) orientQual (
    .mclk(mclk), .resetn(resetn), .s(orientIf.qual));
  settle_qualifier #(.SCALE_SHIFT(WAKE_SCALE_SHIFT)) wakeQual (
    .mclk(mclk), .resetn(resetn), .s(wakeIf.qual));
  settle_qualifier #(.SCALE_SHIFT(SLEEP_SCALE_SHIFT)) sleepQual (
    .mclk(mclk), .resetn(resetn), .s(sleepIf.qual));

  // Accepted states and their one-cycle change pulses
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      orient_r <= FACE_UP;
      active_r <= 1'b0;
      orientChange_r <= 1'b0;
      wakeEvent_r <= 1'b0;
      sleepEvent_r <= 1'b0;
    end else begin
      orientChange_r <= orientIf.accept;
      wakeEvent_r <= wakeIf.accept;
      sleepEvent_r <= sleepIf.accept;
      // The held candidate may already have moved at the accepting tick; the previous one is qualified
      if (orientIf.accept) orient_r <= candPrev_r;
      if (wakeIf.accept) active_r <= 1'b1;
      else if (sleepIf.accept) active_r <= 1'b0;
    end
  end

  assign sdaOut = sdaOut_r;
  assign sdaOe = sdaOe_r;
  assign orientation = orient_r;
  assign orientChange = orientChange_r;
  assign active = active_r;
  assign wakeEvent = wakeEvent_r;
  assign sleepEvent = sleepEvent_r;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  property p_orient_cause;
    orient_r != $past(orient_r) |-> $past(orientIf.accept) && orientChange_r;
  endproperty
  a_orient_cause: assert property (p_orient_cause) else $error("orientation moved unqualified");
  property p_wake_cause;
    $rose(active_r) |-> $past(wakeIf.accept) && wakeEvent_r;
  endproperty
  a_wake_cause: assert property (p_wake_cause) else $error("activity set unqualified");
  property p_sleep_cause;
    $fell(active_r) |-> $past(sleepIf.accept) && sleepEvent_r;
  endproperty
  a_sleep_cause: assert property (p_sleep_cause) else $error("inactivity set unqualified");
  property p_over;
    tick_r && anyOver |=> overHeld_r;
  endproperty
  a_over: assert property (p_over) else $error("axis change above limit missed");
  property p_under;
    tick_r && !allUnder |=> !underHeld_r;
  endproperty
  a_under: assert property (p_under) else $error("quiet flag without all axes under");
  property p_flat;
    tick_r && flat |=> candHeld_r inside {FACE_UP, FACE_DOWN};
  endproperty
  a_flat: assert property (p_flat) else $error("flat sample left face state");
  property p_rot90;
    tick_r && !flat && !accelX[8] && magX > {1'b0, enterLim} && magY < {1'b0, leaveLim}
      && !(magY > {1'b0, enterLim}) |=> candHeld_r == ROT_90;
  endproperty
  a_rot90: assert property (p_rot90) else $error("tilt past enter limit not seen");
  property p_six;
    orient_r inside {FACE_UP, FACE_DOWN, ROT_0, ROT_90, ROT_180, ROT_270};
  endproperty
  a_six: assert property (p_six) else $error("illegal orientation code");
  property p_deadband_read;
    regPtr_r == DEADBAND_OFS |-> rdData[5:4] == 2'b00 && rdData[3:0] == deadbandCode_r;
  endproperty
  a_deadband_read: assert property (p_deadband_read) else $error("deadband read wrong");

  c_wake: cover property ($rose(active_r));
  c_sleep: cover property ($fell(active_r));
  c_orient: cover property (orientChange_r && orient_r == ROT_90);
  c_write: cover property (wrEn && regPtr_r == DEADBAND_OFS);
endmodule // motion_state_qualifier_config

//--- tb/bus_host_model.sv
// Host controller model on the two-wire bus: byte-level read and write tasks.
// Assumes an open-drain data line with a pull-up resolved by the bench.
`timescale 1ns/1ps
module bus_host_model
  import motion_qual_pkg::*;
(
  input wire logic mclk,
  input wire logic sdaLine,
  output logic scl,
  output logic sdaPull
);
  localparam logic [7:0] MIN_INCLINE = 8'h0C;
  // Bus clock stands high while idle
  initial begin
    scl = 1'b1;
    sdaPull = 1'b0;
  end
  // Quarter bus period: 8 mclk, so the bus clock period is 160 ns
  task automatic qtr();
    repeat (8) @(posedge mclk);
  endtask
  task automatic bit_out(input logic b);
    qtr(); sdaPull <= ~b; qtr(); scl <= 1'b1; qtr(); qtr(); scl <= 1'b0;
  endtask
  task automatic bit_in(output logic b);
    qtr(); sdaPull <= 1'b0; qtr(); scl <= 1'b1; qtr(); b = sdaLine; qtr(); scl <= 1'b0;
  endtask
  // Start also serves as repeated start since the line is released first
  task automatic start();
    qtr(); sdaPull <= 1'b0; qtr(); scl <= 1'b1; qtr(); sdaPull <= 1'b1; qtr(); scl <= 1'b0;
  endtask
  task automatic stop();
    qtr(); sdaPull <= 1'b1; qtr(); scl <= 1'b1; qtr(); sdaPull <= 1'b0;
  endtask
  task automatic byte_out(input logic [7:0] d, output logic ack);
    logic a;
    for (int i = 7; i >= 0; i--) bit_out(d[i]);
    bit_in(a);
    ack = ~a;
  endtask
  task automatic write_reg(input logic [7:0] ofs, input logic [7:0] d, output logic ok);
    logic a0, a1, a2;
    start(); byte_out({BUS_ADDR, 1'b0}, a0); byte_out(ofs, a1); byte_out(d, a2); stop();
    ok = a0 & a1 & a2;
  endtask
  // Pointer write then repeated start read; the single byte is closed with a NAK
  task automatic read_reg(input logic [7:0] ofs, output logic [7:0] d, output logic ok);
    logic a0, a1, a2;
    start(); byte_out({BUS_ADDR, 1'b0}, a0); byte_out(ofs, a1);
    start(); byte_out({BUS_ADDR, 1'b1}, a2);
    for (int i = 7; i >= 0; i--) bit_in(d[i]);
    bit_out(1'b1); stop();
    ok = a0 & a1 & a2;
  endtask
  // Trim bits are read back and written unchanged
  task automatic set_deadband(input logic [5:0] low, output logic ok);
    logic [7:0] t;
    read_reg(DEADBAND_OFS, t, ok);
    write_reg(DEADBAND_OFS, {t[7:6], low}, ok);
  endtask
  // Incline limit never goes below the ten degree code
  task automatic set_incline(input logic [7:0] v, output logic ok);
    write_reg(FLAT_INCLINE_OFS, (v < MIN_INCLINE) ? MIN_INCLINE : v, ok);
  endtask
endmodule // bus_host_model

//--- tb/motion_state_qualifier_config_test.sv
// Self-checking bench: registers over the two-wire bus, then motion qualification.
// Assumes the host model above and a short sample period parameter.
`timescale 1ns/1ps
module motion_state_qualifier_config_test
  import motion_qual_pkg::*;
;
  localparam int SC = 20;
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic signed [8:0] accelX = '0, accelY = '0, accelZ = 9'sh040;
  logic toggleOn = 1'b0;
  wire scl, sdaPull, sdaOut, sdaOe, orientChange, active, wakeEvent, sleepEvent;
  wire sdaLine = ~(sdaPull | sdaOe);
  orient_e orientation;
  int numErrors = 0, checkCount = 0, tcnt = 0, n;
  logic ok;
  logic [7:0] d;
  logic [7:0] ofsTab [7] = '{ORIENT_SETTLE_OFS, WAKE_SETTLE_OFS, SLEEP_SETTLE_OFS,
    WAKE_LIMIT_OFS, SLEEP_LIMIT_OFS, FLAT_INCLINE_OFS, DEADBAND_OFS};
  logic [7:0] rstTab [7] = '{ORIENT_SETTLE_RST, WAKE_SETTLE_RST, SLEEP_SETTLE_RST,
    WAKE_LIMIT_RST, SLEEP_LIMIT_RST, FLAT_INCLINE_RST,
    {FACTORY_TRIM_RST, 2'h0, DEADBAND_CODE_RST}};
  // Orientation targets {x, y, z, state}, visiting all six states
  logic [29:0] oriTab [6] = '{{9'h000, 9'h000, 9'h1C0, FACE_DOWN},
    {9'h000, 9'h040, 9'h000, ROT_0}, {9'h040, 9'h000, 9'h000, ROT_90},
    {9'h000, 9'h1C0, 9'h000, ROT_180}, {9'h1C0, 9'h000, 9'h000, ROT_270},
    {9'h000, 9'h000, 9'h040, FACE_UP}};

  always #2.5 mclk = ~mclk;

  motion_state_qualifier_config #(.SAMPLE_CYCLES_P(SC)) u_dut (.mclk(mclk), .resetn(resetn),
    .scl(scl), .sdaIn(sdaLine), .sdaOut(sdaOut), .sdaOe(sdaOe), .accelX(accelX),
    .accelY(accelY), .accelZ(accelZ), .orientation(orientation),
    .orientChange(orientChange), .active(active), .wakeEvent(wakeEvent),
    .sleepEvent(sleepEvent));
  bus_host_model u_host (.mclk(mclk), .sdaLine(sdaLine), .scl(scl), .sdaPull(sdaPull));

  // Flips z once per sample period so every sample sees a large change
  always @(posedge mclk) begin
    tcnt <= (tcnt == SC - 1) ? 0 : tcnt + 1;
    if (toggleOn && tcnt == 0) accelZ <= -accelZ;
  end

  task automatic report_and_stop();
    $display("Errors %0d, checks %0d", numErrors, checkCount);
    if (numErrors == 0 && checkCount > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checkCount++;
    if (got !== exp) begin
      numErrors++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Bounded wait for a one-cycle pulse; n returns the cycles spent
  task automatic wait_sig(input int which, input int bound, output int n);
    logic hit;
    n = 0;
    do begin
      @(posedge mclk); #1; n++;
      hit = (which == 0) ? orientChange : (which == 1) ? wakeEvent : sleepEvent;
    end while (hit !== 1'b1 && n < bound);
    if (hit !== 1'b1) begin
      numErrors++;
      $display("MISMATCH at %0t: pulse %0d never came", $time, which);
      report_and_stop();
    end
  endtask
  task automatic wr(input logic [7:0] ofs, input logic [7:0] v);
    u_host.write_reg(ofs, v, ok);
    chk({7'h0, ok}, 8'h01);
  endtask

  initial begin
    repeat (16) @(posedge mclk);
    resetn <= 1'b1;
    repeat (8) @(posedge mclk);
    // Reset values, then write and read back each plain register
    for (int i = 0; i < 7; i++) begin
      u_host.read_reg(ofsTab[i], d, ok); chk(d, rstTab[i]);
    end
    for (int i = 0; i < 6; i++) begin
      wr(ofsTab[i], 8'hA5 ^ 8'(i)); u_host.read_reg(ofsTab[i], d, ok);
      chk(d, 8'hA5 ^ 8'(i));
    end
    u_host.set_deadband(6'h38, ok); u_host.read_reg(DEADBAND_OFS, d, ok);
    chk(d, {FACTORY_TRIM_RST, 6'h08});
    wr(8'h30, 8'hFF); u_host.read_reg(8'h30, d, ok); chk(d, 8'h00);
    // Settings for the motion checks: orientation count 2, single jumps never wake
    wr(ORIENT_SETTLE_OFS, 8'h02); wr(WAKE_SETTLE_OFS, 8'h02); wr(SLEEP_SETTLE_OFS, 8'h01);
    wr(WAKE_LIMIT_OFS, WAKE_LIMIT_RST); wr(SLEEP_LIMIT_OFS, SLEEP_LIMIT_RST);
    u_host.set_incline(FLAT_INCLINE_RST, ok);
    for (int i = 0; i < 6; i++) begin
      @(posedge mclk);
      {accelX, accelY, accelZ} <= oriTab[i][29:3];
      wait_sig(0, 7 * SC, n); chk({7'h0, n >= 2 * SC}, 8'h01);
      chk({5'h0, orientation}, {5'h0, oriTab[i][2:0]});
    end
    chk({7'h0, active}, 8'h00);
    // Hysteresis: move into the dead zone, then across the 90 degree window
    // Keep z at one g so the later shaking has a nonzero value to flip
    @(posedge mclk); {accelX, accelY, accelZ} <= {9'h000, 9'h040, 9'h040};
    wait_sig(0, 7 * SC, n);
    @(posedge mclk); {accelX, accelY} <= {9'h028, 9'h030};
    repeat (8 * SC) @(posedge mclk);
    chk({5'h0, orientation}, {5'h0, ROT_0});
    @(posedge mclk); {accelX, accelY} <= {9'h038, 9'h01E};
    wait_sig(0, 7 * SC, n); chk({5'h0, orientation}, {5'h0, ROT_90});
    // Brief shaking falls short of the wake count, longer shaking wakes
    @(posedge mclk); toggleOn <= 1'b1;
    repeat (2 * SC) @(posedge mclk);
    toggleOn <= 1'b0;
    repeat (6 * SC) @(posedge mclk);
    chk({7'h0, active}, 8'h00);
    @(posedge mclk); toggleOn <= 1'b1;
    wait_sig(1, 7 * SC, n); chk({7'h0, n >= 2 * SC}, 8'h01);
    chk({7'h0, active}, 8'h01);
    @(posedge mclk); toggleOn <= 1'b0;
    wait_sig(2, 21 * SC, n); chk({7'h0, n >= 15 * SC}, 8'h01);
    chk({7'h0, active}, 8'h00);
    // A high incline limit makes the same tilt count as lying flat
    @(posedge mclk); accelZ <= 9'sh040;
    repeat (4 * SC) @(posedge mclk);
    u_host.set_incline(8'h3A, ok);
    wait_sig(0, 7 * SC, n); chk({5'h0, orientation}, {5'h0, FACE_UP});
    // Open-drain data pin must never drive high
    chk({7'h0, sdaOut}, 8'h00);
    report_and_stop();
  end
endmodule // motion_state_qualifier_config_test
